/* File: design/asbt_map.vh */
// asbt_map.vh - constants for the async serial bit timing and flag block
// assumes: included by bare name from the design files under design/
`ifndef ASBT_MAP_VH
`define ASBT_MAP_VH
// extended mode setting field positions
`define ASBT_EMR_CKSRC_BIT   0
`define ASBT_EMR_BASE8_BIT   1
`define ASBT_EMR_NFEN_BIT    2
`define ASBT_EMR_WIDTH       3
`define ASBT_EMR_RESET       3'h0
// filter clock select: sample every sel+1 base clocks
`define ASBT_NF_SEL_WIDTH    2
`define ASBT_NF_SEL_RESET    2'h0
// base clock cycles per bit, and data bits per frame
`define ASBT_BASE_16         5'h10
`define ASBT_BASE_8          5'h08
`define ASBT_DATA_BITS       4'h8
`endif

/* File: design/asbt_nfilt.v */
// asbt_nfilt.v - digital noise filter for the receive line
// assumes: sample_en is a one-cycle pulse; input synchronous to clock
module asbt_nfilt (
  input  wire clock,
  input  wire sys_rst,
  input  wire sample_en,
  input  wire din,
  output reg  dout
);
  reg [1:0] hist_q;

  // output only changes when three samples in a row agree (two held plus current)
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      hist_q <= 2'h3;
      dout   <= 1'b1;
    end else if (sample_en) begin
      hist_q <= {hist_q[0], din};
      if (hist_q == {din, din})
        dout <= din;
    end
  end
endmodule // asbt_nfilt

/* File: design/asbt_uart.v */
// asbt_uart.v - async serial unit with request flags held outside status
// assumes: one 100 MHz clock; ext and timer clock inputs are synchronous
// level clocks from which rising edges form the base clock
`include "asbt_map.vh"
// How it works
// - status carries no empty or full flag
// - raise tx/rx request flags on ready data
// - servicing a request clears its flag
// - mode bit picks external or timer clock
// - base cycles per bit: 8 or 16
// - mode bit enables receive noise filter
module asbt_uart (
  input  wire                          clock,
  input  wire                          sys_rst,
  input  wire [`ASBT_EMR_WIDTH-1:0]    extended_mode_reg,
  input  wire [`ASBT_NF_SEL_WIDTH-1:0] filter_setting_reg,
  input  wire                          ext_clk_in,
  input  wire                          timer_clock_source,
  input  wire                          tx_wr,
  input  wire [7:0]                    tx_data,
  input  wire                          tx_service_ack,
  input  wire                          tx_sw_clear,
  input  wire                          rx_service_ack,
  input  wire                          rx_sw_clear,
  input  wire                          rxd,
  output reg                           txd,
  output reg  [7:0]                    rx_data,
  output reg                           tx_request,
  output reg                           rx_request,
  output reg                           status_framing_err,
  output reg                           status_overrun_err,
  output reg                           status_tx_end
);
  localparam ST_IDLE  = 2'h0;
  localparam ST_START = 2'h1;
  localparam ST_DATA  = 2'h2;
  localparam ST_STOP  = 2'h3;

  reg       src_q;
  reg       base_en;
  reg [4:0] per_bit;
  reg [1:0] nf_cnt_q;
  reg       nf_en;
  wire      rx_filt;
  wire      rx_line;

  // base clock from the selected source's rising edge
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      src_q <= 1'b0;
    end else begin
      src_q <= extended_mode_reg[`ASBT_EMR_CKSRC_BIT] ? timer_clock_source : ext_clk_in;
    end
  end

  always @* begin
    base_en = (extended_mode_reg[`ASBT_EMR_CKSRC_BIT] ? timer_clock_source : ext_clk_in)
              & ~src_q;
    per_bit = extended_mode_reg[`ASBT_EMR_BASE8_BIT] ? `ASBT_BASE_8 : `ASBT_BASE_16;
    nf_en   = base_en && (nf_cnt_q == 2'h0);
  end

  // filter sampling divider; a setting change only takes effect at wrap
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      nf_cnt_q <= 2'h0;
    end else if (base_en) begin
      nf_cnt_q <= (nf_cnt_q == 2'h0) ? filter_setting_reg : nf_cnt_q - 2'h1;
    end
  end

  asbt_nfilt u_nfilt (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .sample_en (nf_en),
    .din       (rxd),
    .dout      (rx_filt)
  );

  assign rx_line = extended_mode_reg[`ASBT_EMR_NFEN_BIT] ? rx_filt : rxd;

  // transmitter: holding register plus shifter
  reg [1:0] tx_st_q;
  reg [4:0] tx_cnt_q;
  reg [3:0] tx_bit_q;
  reg [7:0] tx_sh_q;
  reg [7:0] tx_hold_q;
  reg       tx_full_q;

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      tx_st_q       <= ST_IDLE;
      tx_cnt_q      <= 5'h00;
      tx_bit_q      <= 4'h0;
      tx_sh_q       <= 8'h00;
      tx_hold_q     <= 8'h00;
      tx_full_q     <= 1'b0;
      txd           <= 1'b1;
      status_tx_end <= 1'b1;
    end else begin
      if (tx_wr) begin
        tx_hold_q <= tx_data;
        tx_full_q <= 1'b1;
      end
      case (tx_st_q)
        ST_IDLE: begin
          if (tx_full_q && !tx_wr) begin
            tx_sh_q       <= tx_hold_q;
            tx_full_q     <= 1'b0;
            tx_st_q       <= ST_START;
            tx_cnt_q      <= 5'h00;
            txd           <= 1'b0;
            status_tx_end <= 1'b0;
          end
        end
        ST_START, ST_DATA, ST_STOP: begin
          if (base_en) begin
            if (tx_cnt_q == per_bit - 5'h01) begin
              tx_cnt_q <= 5'h00;
              case (tx_st_q)
                ST_START: begin
                  tx_st_q  <= ST_DATA;
                  tx_bit_q <= 4'h0;
                  txd      <= tx_sh_q[0];
                end
                ST_DATA: begin
                  if (tx_bit_q == `ASBT_DATA_BITS - 4'h1) begin
                    tx_st_q <= ST_STOP;
                    txd     <= 1'b1;
                  end else begin
                    tx_bit_q <= tx_bit_q + 4'h1;
                    tx_sh_q  <= {1'b0, tx_sh_q[7:1]};
                    txd      <= tx_sh_q[1];
                  end
                end
                default: begin
                  tx_st_q       <= ST_IDLE;
                  status_tx_end <= ~tx_full_q;
                end
              endcase
            end else begin
              tx_cnt_q <= tx_cnt_q + 5'h01;
            end
          end
        end
        default: tx_st_q <= ST_IDLE;
      endcase
    end
  end

  // receiver: samples mid-bit, half a bit after the start edge
  reg [1:0] rx_st_q;
  reg [4:0] rx_cnt_q;
  reg [3:0] rx_bit_q;
  reg [7:0] rx_sh_q;
  reg       rx_done;

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rx_st_q            <= ST_IDLE;
      rx_cnt_q           <= 5'h00;
      rx_bit_q           <= 4'h0;
      rx_sh_q            <= 8'h00;
      rx_data            <= 8'h00;
      rx_done            <= 1'b0;
      status_framing_err <= 1'b0;
      status_overrun_err <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      if (base_en) begin
        case (rx_st_q)
          ST_IDLE: begin
            rx_cnt_q <= 5'h00;
            if (!rx_line)
              rx_st_q <= ST_START;
          end
          ST_START: begin
            if (rx_cnt_q == {1'b0, per_bit[4:1]} - 5'h01) begin
              rx_cnt_q <= 5'h00;
              rx_bit_q <= 4'h0;
              rx_st_q  <= rx_line ? ST_IDLE : ST_DATA; // glitch start rejected
            end else begin
              rx_cnt_q <= rx_cnt_q + 5'h01;
            end
          end
          ST_DATA: begin
            if (rx_cnt_q == per_bit - 5'h01) begin
              rx_cnt_q <= 5'h00;
              rx_sh_q  <= {rx_line, rx_sh_q[7:1]};
              if (rx_bit_q == `ASBT_DATA_BITS - 4'h1)
                rx_st_q <= ST_STOP;
              else
                rx_bit_q <= rx_bit_q + 4'h1;
            end else begin
              rx_cnt_q <= rx_cnt_q + 5'h01;
            end
          end
          ST_STOP: begin
            if (rx_cnt_q == per_bit - 5'h01) begin
              rx_cnt_q           <= 5'h00;
              rx_st_q            <= ST_IDLE;
              status_framing_err <= ~rx_line;
              status_overrun_err <= rx_request;
              if (!rx_request)
                rx_data <= rx_sh_q; // unread data is kept on overrun
              rx_done <= ~rx_request;
            end else begin
              rx_cnt_q <= rx_cnt_q + 5'h01;
            end
          end
          default: rx_st_q <= ST_IDLE;
        endcase
      end
    end
  end

  // request flags live here, not in status; set beats clear
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      tx_request <= 1'b0;
      rx_request <= 1'b0;
    end else begin
      if (tx_st_q == ST_IDLE && tx_full_q && !tx_wr)
        tx_request <= 1'b1;
      else if (tx_service_ack || tx_sw_clear)
        tx_request <= 1'b0;
      if (rx_done)
        rx_request <= 1'b1;
      else if (rx_service_ack || rx_sw_clear)
        rx_request <= 1'b0;
    end
  end
endmodule // asbt_uart

/* File: tb/asbt_partner.sv */
// asbt_partner.sv - remote serial peer: drives rxd, listens on txd
// assumes: bit length in clock cycles; frames are 8N1, lsb first
module asbt_partner (
  input  wire logic clock,
  input  wire logic txd,
  output logic      rxd
);
  timeunit 1ns;
  timeprecision 1ps;
  initial rxd = 1'b1;
  // glitch flips the line for two cycles mid bit 0 (one fast base period):
  // wide enough that a bare mid-bit sampler catches it, short for the filter
  task automatic send(input logic [7:0] b, input int n, input bit glitch);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      for (int k = 0; k < n; k++) begin
        rxd = (glitch && i == 1 && (k == n / 2 || k == n / 2 + 1)) ? !f[i] : f[i];
        @(negedge clock);
      end
    end
  endtask
  // samples mid bit, so small latency in the sender is tolerated
  task automatic recv(input int n, output logic [7:0] b);
    @(negedge txd);
    repeat (n / 2) @(negedge clock);
    for (int i = 0; i < 8; i++) begin
      repeat (n) @(negedge clock);
      b[i] = txd;
    end
  endtask
endmodule // asbt_partner

/* File: tb/asbt_uart_chk.sv */
// asbt_uart_chk.sv - port checker for asbt_uart
// assumes: bound to every asbt_uart; one clock domain
module asbt_chk (
  input wire logic       clock,
  input wire logic       sys_rst,
  input wire logic       tx_wr,
  input wire logic       tx_service_ack,
  input wire logic       tx_sw_clear,
  input wire logic       rx_service_ack,
  input wire logic       rx_sw_clear,
  input wire logic       rxd,
  input wire logic       txd,
  input wire logic [7:0] rx_data,
  input wire logic       tx_request,
  input wire logic       rx_request,
  input wire logic       status_tx_end
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence s_load; tx_wr && status_tx_end; endsequence
  sequence s_start; ##[1:3] (!txd && tx_request); endsequence
  property p_tx_start; s_load |-> s_start; endproperty
  a_tx_start: assert property (p_tx_start) else $error("frame start late");
  property p_tx_hold; tx_request && !tx_service_ack && !tx_sw_clear |=> tx_request; endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx request lost");
  property p_rx_hold; rx_request && !rx_service_ack && !rx_sw_clear |=> rx_request; endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("rx request lost");
  property p_rx_clr; rx_request && (rx_service_ack || rx_sw_clear) && rxd |=> !rx_request;
  endproperty
  a_rx_clr: assert property (p_rx_clr) else $error("rx request kept");
  property p_busy; $fell(txd) |-> !status_tx_end; endproperty
  a_busy: assert property (p_busy) else $error("tx end while sending");
  property p_min_bit; $fell(txd) |=> !txd [*7]; endproperty
  a_min_bit: assert property (p_min_bit) else $error("start bit short");
  property p_rx_data; !$stable(rx_data) |=> $rose(rx_request); endproperty
  a_rx_data: assert property (p_rx_data) else $error("rx data moved");
  property p_idle; status_tx_end |-> txd; endproperty
  a_idle: assert property (p_idle) else $error("idle line low");
endmodule // asbt_chk
bind asbt_uart asbt_chk u_chk (.clock, .sys_rst, .tx_wr, .tx_service_ack, .tx_sw_clear,
  .rx_service_ack, .rx_sw_clear, .rxd, .txd, .rx_data, .tx_request, .rx_request, .status_tx_end);

/* File: tb/asbt_uart_tb_top.sv */
// asbt_uart_tb_top.sv - self-checking bench for asbt_uart
// assumes: peer model asbt_partner; base clocks made here
module asbt_uart_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clock, sys_rst, tx_wr, tx_service_ack, tx_sw_clear, rx_service_ack;
  logic       rx_sw_clear, rxd, txd, tx_request, rx_request, fer, oer, status_tx_end;
  logic [2:0] extended_mode_reg;
  logic [1:0] filter_setting_reg;
  logic [1:0] div_q = 2'h0;
  logic [7:0] tx_data, rx_data;
  int         fails, checks_done, cycles;
  asbt_uart DUT (.clock, .sys_rst, .extended_mode_reg, .filter_setting_reg,
    .ext_clk_in(div_q[0]), .timer_clock_source(div_q[1]), .tx_wr, .tx_data, .tx_service_ack,
    .tx_sw_clear, .rx_service_ack, .rx_sw_clear, .rxd, .txd, .rx_data, .tx_request,
    .rx_request, .status_framing_err(fer), .status_overrun_err(oer), .status_tx_end);
  asbt_partner P (.clock, .txd, .rxd);
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // ext base edge every 2 clocks, timer every 4, so the source shows in bit length
  always @(negedge clock) div_q <= div_q + 2'h1;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      final_report;
    end
  end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // one-cycle clear pulse, handler ack or software clear
  task automatic clr(input bit rx, input bit sw);
    {rx_sw_clear, rx_service_ack, tx_sw_clear, tx_service_ack} = 4'h1 << {rx, sw};
    @(negedge clock);
    {rx_sw_clear, rx_service_ack, tx_sw_clear, tx_service_ack} = 4'h0;
    @(negedge clock);
  endtask
  task automatic t_tx(input logic [2:0] mode, input int n, input bit sw);
    logic [7:0] got;
    extended_mode_reg = mode;
    tx_data = 8'hA5 ^ {5'h00, mode};
    tx_wr = 1'b1;
    fork
      P.recv(n, got);
      @(negedge clock) tx_wr = 1'b0;
    join
    check("tx byte", got, tx_data);
    check("tx request", {7'h00, tx_request}, 8'h01);
    clr(1'b0, sw);
    check("tx request cleared", {7'h00, tx_request}, 8'h00);
    repeat (2 * n) @(negedge clock);
    check("tx end", {7'h00, status_tx_end}, 8'h01);
    $display("test tx mode %0d done", mode);
  endtask
  task automatic t_rx;
    extended_mode_reg = 3'h0;
    P.send(8'h3C, 32, 1'b0);
    check("rx byte", rx_data, 8'h3C);
    check("rx request", {7'h00, rx_request}, 8'h01);
    check("framing", {7'h00, fer}, 8'h00);
    clr(1'b1, 1'b1);
    check("rx request cleared", {7'h00, rx_request}, 8'h00);
    P.send(8'hC3, 32, 1'b0);
    P.send(8'h11, 32, 1'b0);
    check("rx kept", rx_data, 8'hC3);
    check("overrun", {6'h00, oer, rx_request}, 8'h03);
    clr(1'b1, 1'b0);
    check("rx request acked", {7'h00, rx_request}, 8'h00);
    $display("test rx done");
  endtask
  // both a fast and a slower filter clock; the filter delays the whole frame
  task automatic t_filter;
    extended_mode_reg = 3'h4;
    for (int s = 0; s < 2; s++) begin
      filter_setting_reg = s[1:0];
      P.send(8'h5A ^ s[7:0], 32, 1'b1);
      repeat (16) @(negedge clock);
      check("filtered byte", rx_data, 8'h5A ^ s[7:0]);
      check("filter request", {7'h00, rx_request}, 8'h01);
      clr(1'b1, 1'b0);
    end
    $display("test filter done");
  endtask
  initial begin
    {tx_wr, tx_service_ack, tx_sw_clear, rx_service_ack, rx_sw_clear} = 5'h00;
    {sys_rst, extended_mode_reg, filter_setting_reg, tx_data} = {1'b1, 13'h0000};
    repeat (4) @(negedge clock);
    sys_rst = 1'b0;
    check("reset", {5'h00, txd, tx_request, status_tx_end}, 8'h05);
    t_tx(3'h0, 32, 1'b0);
    t_tx(3'h2, 16, 1'b1);
    t_tx(3'h1, 64, 1'b0);
    t_tx(3'h3, 32, 1'b1);
    t_rx;
    t_filter;
    final_report;
  end
endmodule // asbt_uart_tb_top
